// file: dbg_uart_pkg.sv
// dbg_uart_pkg: register map, field positions, reset values and modes of the debug uart
// assumes a single 100 MHz clock and a plain address/strobe register port
package dbg_uart_pkg;
  // register byte offsets
  localparam logic [7:0] CMD_OFS     = 8'h00;
  localparam logic [7:0] MODE_OFS    = 8'h04;
  localparam logic [7:0] IEN_OFS     = 8'h08;
  localparam logic [7:0] IDIS_OFS    = 8'h0C;
  localparam logic [7:0] IMASK_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS    = 8'h14;
  localparam logic [7:0] RHOLD_OFS   = 8'h18;
  localparam logic [7:0] THOLD_OFS   = 8'h1C;
  localparam logic [7:0] BAUD_OFS    = 8'h20;
  localparam logic [7:0] PID_OFS     = 8'h40;
  localparam logic [7:0] PIDX_OFS    = 8'h44;
  localparam logic [7:0] PBLK_OFS    = 8'h48;
  // command bits
  localparam int RX_RST_BIT  = 2;
  localparam int TX_RST_BIT  = 3;
  localparam int RX_EN_BIT   = 4;
  localparam int RX_DIS_BIT  = 5;
  localparam int TX_EN_BIT   = 6;
  localparam int TX_DIS_BIT  = 7;
  localparam int ERR_CLR_BIT = 8;
  // mode fields
  localparam int CHK_LSB  = 9;
  localparam int CHK_MSB  = 11;
  localparam int CHAN_LSB = 14;
  localparam int CHAN_MSB = 15;
  localparam logic [31:0] MODE_WMASK = 32'h0000CE00;
  localparam logic [31:0] MODE_RST   = 32'h00000000;
  localparam logic [31:0] MASK_RST   = 32'h00000000;
  localparam logic [15:0] BAUD_RST   = 16'h0000;
  // status / interrupt bit positions
  localparam int RX_READY_BIT = 0;
  localparam int TX_READY_BIT = 1;
  localparam int RX_END_BIT   = 3;
  localparam int TX_END_BIT   = 4;
  localparam int OVR_BIT    = 5;
  localparam int FRM_BIT    = 6;
  localparam int CHKE_BIT   = 7;
  localparam int TXIDLE_BIT = 9;
  localparam int TX_DRAIN_BIT = 11;
  localparam int RX_FULL_BIT  = 12;
  localparam int DCWR_BIT   = 30;
  localparam int DCRD_BIT   = 31;
  localparam logic [31:0] IRQ_VALID = 32'hC0001AFB;
  // check-bit kinds, channel modes and shifter states
  localparam logic [2:0] CHK_EVEN  = 3'h0;
  localparam logic [2:0] CHK_ODD   = 3'h1;
  localparam logic [2:0] CHK_SPACE = 3'h2;
  localparam logic [2:0] CHK_MARK  = 3'h3;
  typedef enum logic [1:0] {
    CHAN_NORMAL = 2'b00,
    CHAN_ECHO   = 2'b01,
    CHAN_LOCAL  = 2'b10,
    CHAN_REMOTE = 2'b11
  } chan_mode_t;
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_BITS  = 2'b10,
    SER_STOP  = 2'b11
  } ser_state_t;
  // identity values are arbitrary
  localparam logic [31:0] PART_ID_VAL  = 32'h12345670;
  localparam logic [31:0] PART_IDX_VAL = 32'h00000000;
  localparam logic [15:0] OVS_COUNT    = 16'h0010;
endpackage

// file: dbg_uart.sv
// dbg_uart: debug two-wire uart with command, mode and interrupt mask registers
// assumes the register master follows the one-cycle strobe protocol; pins are asynchronous
`timescale 1ns/100ps

module dbg_uart (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        serial_receive_pin_i,
  output logic             serial_transmit_pin_o,
  input  wire logic        receive_transfer_end_i,
  input  wire logic        transmit_transfer_end_i,
  input  wire logic        transmit_buffer_drained_i,
  input  wire logic        receive_buffer_filled_i,
  input  wire logic        debug_channel_write_pending_i,
  input  wire logic        debug_channel_read_pending_i,
  output logic             debug_port_block_o,
  output logic             irq_o
);
  import dbg_uart_pkg::*;

  logic [31:0] mode_q, mask_q, status;
  logic [15:0] baud_q;
  logic        pblk_q;
  chan_mode_t  chan;
  logic [2:0]  chk;
  logic        wr_cmd, wr_ien, wr_idis, rd_rhold, wr_thold;
  logic        rx_s1_q, rx_s2_q;
  logic [5:0]  side_s1_q, side_s2_q;

  // parity of a byte per check-bit kind; used by both shifters
  function automatic logic chk_bit(input logic [7:0] d, input logic [2:0] k);
    logic r;
    r = 1'b0;
    if (k == CHK_EVEN) begin
      r = ^d;
    end else if (k == CHK_ODD) begin
      r = ~(^d);
    end else if (k == CHK_MARK) begin
      r = 1'b1;
    end
    return r;
  endfunction

  assign chan     = chan_mode_t'(mode_q[CHAN_MSB:CHAN_LSB]);
  assign chk      = mode_q[CHK_MSB:CHK_LSB];
  assign wr_cmd   = reg_wr_i && (reg_addr_i == CMD_OFS);
  assign wr_ien   = reg_wr_i && (reg_addr_i == IEN_OFS);
  assign wr_idis  = reg_wr_i && (reg_addr_i == IDIS_OFS);
  assign wr_thold = reg_wr_i && (reg_addr_i == THOLD_OFS);
  assign rd_rhold = reg_rd_i && (reg_addr_i == RHOLD_OFS);

  // two-flop synchronisers for the pin and the side-band status inputs
  always_ff @(posedge core_clk_i) begin
    rx_s1_q   <= serial_receive_pin_i;
    rx_s2_q   <= rx_s1_q;
    side_s1_q <= {debug_channel_read_pending_i, debug_channel_write_pending_i,
                  receive_buffer_filled_i, transmit_buffer_drained_i,
                  transmit_transfer_end_i, receive_transfer_end_i};
    side_s2_q <= side_s1_q;
  end

  // mode, baud divisor and block registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_q <= MODE_RST;
      baud_q <= BAUD_RST;
      pblk_q <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == MODE_OFS) begin
        mode_q <= reg_wdata_i & MODE_WMASK;
      end else if (reg_addr_i == BAUD_OFS) begin
        baud_q <= reg_wdata_i[15:0];
      end else if (reg_addr_i == PBLK_OFS) begin
        pblk_q <= reg_wdata_i[0];
      end
    end
  end
  assign debug_port_block_o = pblk_q;

  // interrupt mask: enable sets, disable clears, other bits kept
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mask_q <= MASK_RST;
    end else if (wr_ien) begin
      mask_q <= mask_q | (reg_wdata_i & IRQ_VALID);
    end else if (wr_idis) begin
      mask_q <= mask_q & ~(reg_wdata_i & IRQ_VALID);
    end
  end

  // baud tick: 16x oversample enable; cd of 1 gives every cycle, 0 stops it
  logic [15:0] bdiv_q;
  logic        tick;
  assign tick = (baud_q != 16'h0000) && (bdiv_q == 16'h0000);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || tick) begin
      bdiv_q <= (baud_q == 16'h0000) ? 16'h0000 : baud_q - 16'h0001;
    end else if (bdiv_q != 16'h0000) begin
      bdiv_q <= bdiv_q - 16'h0001;
    end
  end

  // transmitter: enable state, holding register and shifter
  logic       tx_en_q, tx_stop_q, thr_full_q, tx_line_q;
  logic [7:0] thr_q, tsh_q;
  ser_state_t tst_q;
  logic [3:0] tcnt_q, tbit_q;
  logic       tx_busy, tx_run;
  assign tx_busy = (tst_q != SER_IDLE);
  assign tx_run  = tx_en_q && (chan != CHAN_REMOTE);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || (wr_cmd && reg_wdata_i[TX_RST_BIT])) begin
      tx_en_q    <= 1'b0;
      tx_stop_q  <= 1'b0;
      thr_full_q <= 1'b0;
      tst_q      <= SER_IDLE;
      tx_line_q  <= 1'b1;
      tcnt_q     <= 4'h0;
      tbit_q     <= 4'h0;
      tsh_q      <= 8'h00;
      thr_q      <= 8'h00;
    end else begin
      // pending disable takes effect once both shifter and holding are empty;
      // placed first so a command written in the same cycle still wins
      if (tx_stop_q && !tx_busy && !thr_full_q) begin
        tx_en_q   <= 1'b0;
        tx_stop_q <= 1'b0;
      end
      if (wr_cmd && reg_wdata_i[TX_DIS_BIT]) begin
        tx_stop_q <= 1'b1;
      end else if (wr_cmd && reg_wdata_i[TX_EN_BIT]) begin
        tx_en_q   <= 1'b1;
        tx_stop_q <= 1'b0;
      end
      if (wr_thold && tx_en_q) begin
        thr_q      <= reg_wdata_i[7:0];
        thr_full_q <= 1'b1;
      end
      case (tst_q)
        SER_IDLE: begin
          tx_line_q <= 1'b1;
          if (thr_full_q && tx_run) begin
            tsh_q      <= thr_q;
            thr_full_q <= wr_thold;
            tst_q      <= SER_START;
            tcnt_q     <= 4'h0;
          end
        end
        SER_START: begin
          tx_line_q <= 1'b0;
          if (tick) begin
            tcnt_q <= tcnt_q + 4'h1;
            if (tcnt_q == 4'hF) begin
              tst_q  <= SER_BITS;
              tbit_q <= 4'h0;
            end
          end
        end
        SER_BITS: begin
          tx_line_q <= (tbit_q == 4'h8) ? chk_bit(tsh_q, chk) : tsh_q[tbit_q[2:0]];
          if (tick) begin
            tcnt_q <= tcnt_q + 4'h1;
            if (tcnt_q == 4'hF) begin
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == (chk[2] ? 4'h7 : 4'h8)) begin
                tst_q <= SER_STOP;
              end
            end
          end
        end
        SER_STOP: begin
          tx_line_q <= 1'b1;
          if (tick) begin
            tcnt_q <= tcnt_q + 4'h1;
            if (tcnt_q == 4'hF) begin
              tst_q <= SER_IDLE;
            end
          end
        end
        default: tst_q <= SER_IDLE;
      endcase
    end
  end

  // pin routing per channel mode
  logic rx_line;
  always_comb begin
    serial_transmit_pin_o = tx_line_q;
    rx_line               = rx_s2_q;
    case (chan)
      CHAN_ECHO:   serial_transmit_pin_o = rx_s2_q;
      CHAN_LOCAL: begin
        serial_transmit_pin_o = 1'b1;
        rx_line               = tx_line_q;
      end
      CHAN_REMOTE: begin
        serial_transmit_pin_o = rx_s2_q;
        rx_line               = 1'b1;
      end
      default:     serial_transmit_pin_o = tx_line_q;
    endcase
  end

  // receiver: samples mid-bit at 16x; disable waits for the frame to end
  logic       rx_en_q, rx_stop_q, rx_ready_q, ovr_q, frm_q, chke_q;
  logic [7:0] rsh_q, rhr_q;
  ser_state_t rst_q;
  logic [3:0] rcnt_q, rbit_q;
  logic       rx_done, rx_err_clr;
  assign rx_err_clr = wr_cmd && reg_wdata_i[ERR_CLR_BIT];
  // stop bit judged in its middle, sixteen ticks after the last bit sample
  assign rx_done    = (rst_q == SER_STOP) && tick && (rcnt_q == 4'hF);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || (wr_cmd && reg_wdata_i[RX_RST_BIT])) begin
      rx_en_q   <= 1'b0;
      rx_stop_q <= 1'b0;
      rst_q     <= SER_IDLE;
      rcnt_q    <= 4'h0;
      rbit_q    <= 4'h0;
      rsh_q     <= 8'h00;
    end else begin
      // pending stop first, so an enable written in this cycle is kept
      if (rx_stop_q && (rst_q == SER_IDLE)) begin
        rx_en_q   <= 1'b0;
        rx_stop_q <= 1'b0;
      end
      if (wr_cmd && reg_wdata_i[RX_DIS_BIT]) begin
        rx_stop_q <= 1'b1;
      end else if (wr_cmd && reg_wdata_i[RX_EN_BIT]) begin
        rx_en_q   <= 1'b1;
        rx_stop_q <= 1'b0;
      end
      case (rst_q)
        SER_IDLE: begin
          rcnt_q <= 4'h0;
          if (rx_en_q && !rx_stop_q && (chan != CHAN_REMOTE) && !rx_line) begin
            rst_q <= SER_START;
          end
        end
        SER_START: if (tick) begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == 4'h7) begin
            rst_q  <= rx_line ? SER_IDLE : SER_BITS; // glitch rejects
            rcnt_q <= 4'h0;
            rbit_q <= 4'h0;
          end
        end
        SER_BITS: if (tick) begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == 4'hF) begin
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q < 4'h8) begin
              rsh_q <= {rx_line, rsh_q[7:1]};
            end
            if (rbit_q == (chk[2] ? 4'h7 : 4'h8)) begin
              rst_q <= SER_STOP;
            end
          end
        end
        SER_STOP: if (tick) begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == 4'hF) begin
            rst_q <= SER_IDLE;
          end
        end
        default: rst_q <= SER_IDLE;
      endcase
    end
  end

  // received check bit, caught on the ninth bit sample
  logic rchk_q;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rchk_q <= 1'b0;
    end else if ((rst_q == SER_BITS) && tick && (rcnt_q == 4'hF) && (rbit_q == 4'h8)) begin
      rchk_q <= rx_line;
    end
  end

  // holding register and sticky flags; a set in the clear cycle wins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rhr_q      <= 8'h00;
      rx_ready_q <= 1'b0;
      ovr_q      <= 1'b0;
      frm_q      <= 1'b0;
      chke_q     <= 1'b0;
    end else begin
      if (rx_err_clr) begin
        ovr_q  <= 1'b0;
        frm_q  <= 1'b0;
        chke_q <= 1'b0;
      end
      if (rd_rhold) begin
        rx_ready_q <= 1'b0;
      end
      // receiver reset also drops a character that was never read
      if (wr_cmd && reg_wdata_i[RX_RST_BIT]) begin
        rx_ready_q <= 1'b0;
      end
      if (rx_done) begin
        rhr_q      <= rsh_q;
        rx_ready_q <= 1'b1;
        if (rx_ready_q && !rd_rhold) begin
          ovr_q <= 1'b1;
        end
        if (!rx_line) begin
          frm_q <= 1'b1;
        end
        if (!chk[2] && (rchk_q != chk_bit(rsh_q, chk))) begin
          chke_q <= 1'b1;
        end
      end
    end
  end

  // status word and interrupt
  always_comb begin
    status             = 32'h00000000;
    status[RX_READY_BIT] = rx_ready_q && rx_en_q;
    status[TX_READY_BIT] = tx_en_q && !thr_full_q;
    status[RX_END_BIT]   = side_s2_q[0];
    status[TX_END_BIT]   = side_s2_q[1];
    status[OVR_BIT]    = ovr_q;
    status[FRM_BIT]    = frm_q;
    status[CHKE_BIT]   = chke_q;
    status[TXIDLE_BIT] = tx_en_q && !thr_full_q && !tx_busy;
    status[TX_DRAIN_BIT] = side_s2_q[2];
    status[RX_FULL_BIT]  = side_s2_q[3];
    status[DCWR_BIT]   = side_s2_q[4];
    status[DCRD_BIT]   = side_s2_q[5];
  end
  assign irq_o = |(status & mask_q);

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == MODE_OFS) begin
        reg_rdata_o <= mode_q;
      end else if (reg_addr_i == IMASK_OFS) begin
        reg_rdata_o <= mask_q;
      end else if (reg_addr_i == STAT_OFS) begin
        reg_rdata_o <= status;
      end else if (reg_addr_i == RHOLD_OFS) begin
        reg_rdata_o <= {24'h000000, rhr_q};
      end else if (reg_addr_i == BAUD_OFS) begin
        reg_rdata_o <= {16'h0000, baud_q};
      end else if (reg_addr_i == PID_OFS) begin
        reg_rdata_o <= PART_ID_VAL;
      end else if (reg_addr_i == PIDX_OFS) begin
        reg_rdata_o <= PART_IDX_VAL;
      end else if (reg_addr_i == PBLK_OFS) begin
        reg_rdata_o <= {31'h00000000, pblk_q};
      end else begin
        reg_rdata_o <= 32'h00000000;
      end
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // checks
  AST_RXRST_DISABLES: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_cmd && reg_wdata_i[RX_RST_BIT]) |=> (!rx_en_q && rst_q == SER_IDLE))
    else $error("receiver reset did not disable");
  AST_TXRST_DISABLES: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_cmd && reg_wdata_i[TX_RST_BIT]) |=> (!tx_en_q && !tx_busy && !thr_full_q))
    else $error("transmitter reset did not disable");
  AST_RX_DIS_WINS: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_cmd && reg_wdata_i[RX_EN_BIT] && reg_wdata_i[RX_DIS_BIT] && !rx_en_q
     && !reg_wdata_i[RX_RST_BIT]) |=> !rx_en_q)
    else $error("receiver enabled despite disable");
  AST_TX_EN: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_cmd && reg_wdata_i[TX_EN_BIT] && !reg_wdata_i[TX_DIS_BIT]
     && !reg_wdata_i[TX_RST_BIT]) |=> tx_en_q)
    else $error("transmitter not enabled");
  AST_TX_DRAIN: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tx_stop_q && tx_busy) |-> tx_en_q)
    else $error("transmitter stopped mid character");
  AST_ERR_CLR: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (rx_err_clr && !rx_done) |=> (!ovr_q && !frm_q && !chke_q))
    else $error("error flags not cleared");
  AST_MASK_SET: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_ien |=> ((mask_q & $past(reg_wdata_i) & IRQ_VALID) == ($past(reg_wdata_i) & IRQ_VALID)))
    else $error("mask bit not set");
  AST_MASK_CLR: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_idis |=> ((mask_q & $past(reg_wdata_i)) == 32'h00000000))
    else $error("mask bit not cleared");
  AST_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_o == ((status & mask_q) != 32'h00000000))
    else $error("interrupt level wrong");
  AST_LOCAL_HIGH: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (chan == CHAN_LOCAL) |-> serial_transmit_pin_o)
    else $error("transmit pin not idle in local loopback");
  AST_OVERRUN: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (rx_done && rx_ready_q && !rd_rhold) |=> ovr_q)
    else $error("overrun not flagged");
  COV_RX_CHAR: cover property (@(posedge core_clk_i) rx_done);
  COV_TX_START: cover property (@(posedge core_clk_i) tst_q == SER_START);
  COV_OVERRUN: cover property (@(posedge core_clk_i) rx_done && rx_ready_q);
  COV_IRQ: cover property (@(posedge core_clk_i) irq_o);
endmodule

// file: dbg_uart_term.sv
// dbg_uart_term: serial terminal on the far side of the debug uart line
// assumes BIT_CYC clocks per bit, 8 data bits lsb first, line idles high
`timescale 1ns/100ps
module dbg_uart_term #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // the terminal keeps its line at the idle level between frames
  initial line_o = 1'b1;

  // hold the line at a level, for the pin-to-pin test modes
  task automatic drive(input logic v);
    @(posedge clk_i);
    line_o <= v;
  endtask

  // one frame with a check bit; an extra stop bit costs nothing
  task automatic send(input logic [7:0] ch, input logic chk);
    logic [10:0] fr;
    fr = {1'b1, chk, ch, 1'b0};
    @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      line_o <= fr[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask

  // sample start, data and the tenth bit in mid-bit; bounded wait for start
  task automatic recv(output logic [9:0] got, output logic ok);
    int t;
    t = 0;
    while (line_i !== 1'b0 && t < 4000) begin
      @(posedge clk_i);
      t++;
    end
    ok = t < 4000;
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      got[i] = line_i;
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
endmodule

// file: test_dbg_uart.sv
// test_dbg_uart: self-checking bench for the debug uart registers and line
// assumes dbg_uart_term as the terminal and a divisor of 1 (16 clocks a bit)
`timescale 1ns/100ps
module test_dbg_uart;
  import dbg_uart_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        core_clk_i;
  logic        srst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        rx_line;
  logic        tx_line;
  logic [5:0]  ext_q = 6'h00;
  logic        blk;
  logic        irq_o;
  int          bad_count = 0;
  int          tests_run = 0;
  int          pos [6] = '{3, 4, 11, 12, 30, 31};

  dbg_uart i_dbg_uart (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .serial_receive_pin_i(rx_line),
    .serial_transmit_pin_o(tx_line), .receive_transfer_end_i(ext_q[0]),
    .transmit_transfer_end_i(ext_q[1]), .transmit_buffer_drained_i(ext_q[2]),
    .receive_buffer_filled_i(ext_q[3]), .debug_channel_write_pending_i(ext_q[4]),
    .debug_channel_read_pending_i(ext_q[5]), .debug_port_block_o(blk), .irq_o(irq_o));
  dbg_uart_term i_dbg_uart_term (.clk_i(core_clk_i), .line_i(tx_line), .line_o(rx_line));

  // 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one-cycle strobes; a gap cycle keeps each strobe a clean pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o & m, e);
  endtask

  task automatic tx_frame(input logic [9:0] e);
    logic [9:0] got;
    logic       ok;
    i_dbg_uart_term.recv(got, ok);
    if (!ok) begin
      bad_count++;
      conclude();
    end else begin
      chk({22'h0, got}, {22'h0, e});
    end
  endtask

  // count cycles in which the transmit pin leaves the idle level
  task automatic hold_high(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(posedge core_clk_i);
      if (tx_line !== 1'b1) lows++;
    end
    chk(32'(lows), 32'h0);
  endtask

  task automatic t_regs();
    rdchk(MODE_OFS, ALL, 32'h0);
    rdchk(IMASK_OFS, ALL, 32'h0);
    rdchk(8'h24, ALL, 32'h0);
    rdchk(PBLK_OFS, ALL, 32'h0);
    wr(PBLK_OFS, 32'h1);
    #1 chk({31'h0, blk}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wr(MODE_OFS, ALL);
    rdchk(MODE_OFS, ALL, 32'h0000CE00);
    wr(MODE_OFS, 32'h0);
    wr(IEN_OFS, ALL);
    rdchk(IMASK_OFS, ALL, 32'hC0001AFB);
    wr(IDIS_OFS, 32'h000000E0);
    wr(IEN_OFS, 32'h0);
    rdchk(IMASK_OFS, ALL, 32'hC0001A1B);
    wr(IDIS_OFS, ALL);
    rdchk(IMASK_OFS, ALL, 32'h0);
  endtask

  // each external source shows in status and drives irq only when unmasked
  task automatic t_irq();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      ext_q[i] <= 1'b1;
      cyc(4);
      rdchk(STAT_OFS, 32'h1 << pos[i], 32'h1 << pos[i]);
      chk({31'h0, irq_o}, 32'h0);
      wr(IEN_OFS, 32'h1 << pos[i]);
      #1 chk({31'h0, irq_o}, 32'h1);
      wr(IDIS_OFS, 32'h1 << pos[i]);
      #1 chk({31'h0, irq_o}, 32'h0);
      @(posedge core_clk_i);
      ext_q[i] <= 1'b0;
    end
  endtask

  // check-bit codes 0 to 4 on 0xA7, which holds five ones
  task automatic t_tx();
    logic [4:0] b9;
    b9 = 5'b11001;
    wr(BAUD_OFS, 32'h1);
    rdchk(BAUD_OFS, ALL, 32'h1);
    wr(CMD_OFS, 32'h40);
    rdchk(STAT_OFS, 32'h202, 32'h202);
    for (int i = 0; i < 5; i++) begin
      wr(MODE_OFS, 32'(i) << 9);
      wr(THOLD_OFS, 32'hA7);
      tx_frame({b9[i], 8'hA7, 1'b0});
      cyc(40);
    end
    wr(MODE_OFS, 32'h0);
    wr(THOLD_OFS, 32'h81);
    wr(THOLD_OFS, 32'h42);
    wr(CMD_OFS, 32'h80);
    tx_frame({1'b0, 8'h81, 1'b0});
    tx_frame({1'b0, 8'h42, 1'b0});
    cyc(40);
    wr(CMD_OFS, 32'hC0);
    wr(THOLD_OFS, 32'h12);
    hold_high(200);
    wr(CMD_OFS, 32'h40);
    wr(THOLD_OFS, 32'h00);
    cyc(40);
    wr(CMD_OFS, 32'h08);
    cyc(3);
    hold_high(200);
    rdchk(STAT_OFS, 32'h202, 32'h0);
  endtask

  // reception, check-bit error, overrun, clearing and the receiver commands
  task automatic t_rx();
    wr(CMD_OFS, 32'h10);
    i_dbg_uart_term.send(8'h3C, 1'b0);
    cyc(20);
    rdchk(STAT_OFS, 32'hE1, 32'h01);
    rdchk(RHOLD_OFS, 32'hFF, 32'h3C);
    i_dbg_uart_term.send(8'h3C, 1'b1);
    i_dbg_uart_term.send(8'h3D, 1'b1);
    cyc(20);
    rdchk(STAT_OFS, 32'hE1, 32'hA1);
    wr(CMD_OFS, 32'h100);
    rdchk(STAT_OFS, 32'hE1, 32'h01);
    rdchk(RHOLD_OFS, 32'hFF, 32'h3D);
    fork
      i_dbg_uart_term.send(8'h55, 1'b0);
      begin
        cyc(40);
        wr(CMD_OFS, 32'h20);
      end
    join
    cyc(20);
    rdchk(RHOLD_OFS, 32'hFF, 32'h55);
    wr(CMD_OFS, 32'h10);
    wr(CMD_OFS, 32'h30);
    i_dbg_uart_term.send(8'h66, 1'b0);
    cyc(20);
    wr(CMD_OFS, 32'h10);
    rdchk(STAT_OFS, 32'h1, 32'h0);
    // an unread character must not survive the receiver reset below
    i_dbg_uart_term.send(8'h5A, 1'b0);
    rdchk(STAT_OFS, 32'h1, 32'h1);
    fork
      i_dbg_uart_term.send(8'h0F, 1'b0);
      begin
        cyc(40);
        wr(CMD_OFS, 32'h04);
      end
    join
    wr(CMD_OFS, 32'h10);
    cyc(20);
    rdchk(STAT_OFS, 32'h1, 32'h0);
  endtask

  // echo and remote copy the receive pin; local loopback keeps it high
  task automatic t_chan();
    for (int i = 1; i < 4; i += 2) begin
      wr(MODE_OFS, 32'(i) << 14);
      i_dbg_uart_term.drive(1'b0);
      cyc(6);
      #1 chk({31'h0, tx_line}, 32'h0);
      i_dbg_uart_term.drive(1'b1);
      cyc(6);
      #1 chk({31'h0, tx_line}, 32'h1);
    end
    wr(MODE_OFS, 32'h8000);
    i_dbg_uart_term.drive(1'b0);
    wr(CMD_OFS, 32'h50);
    wr(THOLD_OFS, 32'h5A);
    hold_high(250);
    i_dbg_uart_term.drive(1'b1);
    rdchk(RHOLD_OFS, 32'hFF, 32'h5A);
  endtask

  // main sequence: 6 cycles of reset, then the scenarios
  initial begin
    repeat (6) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_irq();
    t_tx();
    t_rx();
    t_chan();
    conclude();
  end

  // a hang ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge core_clk_i);
    bad_count++;
    conclude();
  end
endmodule
